// ==== design/subsys_boot_regs.svh ====
// constants for the subsystem reset and boot handshake block
`ifndef SUBSYS_BOOT_REGS_SVH
`define SUBSYS_BOOT_REGS_SVH
`define BOOT_CMD_W 32
`define BOOT_CMD_RAM 32'h0000_0001
`define BOOT_CMD_FLASH 32'h0000_0002
`define BOOT_CMD_SERIAL 32'h0000_0003
`define BOOT_CMD_SPI 32'h0000_0004
`define BOOT_CMD_I2C 32'h0000_0005
`define BOOT_CMD_PARALLEL 32'h0000_0006
`define BOOT_CMD_SPI_ALT 32'h0000_0007
`define WAKE_IRQ_NUM 2'h1
`define POR_TIME_NS 1000
`define CLK_PERIOD_NS 4
`define POR_CYCLES (`POR_TIME_NS / `CLK_PERIOD_NS)
`define POR_CNT_W 10
`define SYNC_DEPTH 3
`define REQ_HOLD_W 3
`define REQ_HOLD_CYCLES 3'h4
`endif

// ==== design/subsys_boot_pkg.sv ====
// types for the subsystem reset and boot handshake block
package subsys_boot_pkg;
	typedef enum logic [3:0] {
		CB_RESET,
		CB_INIT,
		CB_IDLE,
		CB_WAIT_CMD,
		CB_LOAD,
		CB_BRANCH,
		CB_RUN
	} ctrl_boot_state_t;
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_RAM,
		SRC_FLASH,
		SRC_SERIAL,
		SRC_SPI,
		SRC_I2C,
		SRC_PARALLEL,
		SRC_SPI_ALT
	} boot_source_t;
	typedef enum logic [1:0] {
		PB_RESET,
		PB_LOAD,
		PB_RUN
	} prim_boot_state_t;
endpackage

// ==== design/pin_sync.sv ====
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pinIn,
	output logic level
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_level;
	always_comb begin
		next_stage = {stage[1:0], pinIn};
		next_level = level;
		// first stage is never looked at; only stages two and three vote
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stage <= 3'h0;
			level <= 1'b0;
		end else begin
			stage <= next_stage;
			level <= next_level;
		end
	end
endmodule
`default_nettype wire

// ==== design/boot_cmd_decode.sv ====
// decodes a control boot-mode command into a boot source
`timescale 1ns/1ps
`default_nettype none
`include "subsys_boot_regs.svh"
module boot_cmd_decode (
	input wire logic [`BOOT_CMD_W-1:0] cmd,
	output subsys_boot_pkg::boot_source_t source,
	output logic valid
);
	import subsys_boot_pkg::*;
	always_comb begin
		valid = 1'b1;
		case (cmd)
			`BOOT_CMD_RAM: source = SRC_RAM;
			`BOOT_CMD_FLASH: source = SRC_FLASH;
			`BOOT_CMD_SERIAL: source = SRC_SERIAL;
			`BOOT_CMD_SPI: source = SRC_SPI;
			`BOOT_CMD_I2C: source = SRC_I2C;
			`BOOT_CMD_PARALLEL: source = SRC_PARALLEL;
			`BOOT_CMD_SPI_ALT: source = SRC_SPI_ALT;
			default: begin
				source = SRC_NONE;
				valid = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ==== design/subsystem_reset_boot_handshake.sv ====
// reset merging, subsystem release and control boot command handshake
// Behaviour
// - primary boot branches to its application once the image is present
// - control boot parks idle; primary wake interrupt number 1 wakes it
// - control boot proceeds only through commands sent by the primary side
// - command 1 branches to control RAM entry point
// - command 2 branches to control flash entry point
// - command 3 loads over the asynchronous serial port
// - command 4 loads over SPI on default terminals
// - command 5 loads over I2C
// - command 6 loads in parallel over general-purpose pins
// - command 7 loads over SPI on alternate terminals
// - once control image resides, boot loader branches to it
// - after boot, further commands are still acknowledged and their source recorded, but start no new load or branch
// - power-on reset drives both reset pins low during power-up
// - during power-on reset, logic is reset and GPIO goes high impedance
// - watchdog and interrupt-controller resets merge with power-on onto digital pin
// - after power-up only the primary subsystem leaves reset
// - control and analog stay in reset until release bits written 1
// - both reset pins low together reset both; release together
`timescale 1ns/1ps
`default_nettype none
`include "subsys_boot_regs.svh"
module subsystem_reset_boot_handshake (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic analog_reset_pin_n_in,
	output logic analog_reset_pin_n_out,
	output logic analog_reset_pin_n_oe,
	input wire logic digital_reset_pin_n_in,
	output logic digital_reset_pin_n_out,
	output logic digital_reset_pin_n_oe,
	input wire logic intCtrlResetReq,
	input wire logic watchdog0ResetReq,
	input wire logic watchdog1ResetReq,
	input wire logic nmiWatchdogResetReq,
	input wire logic control_reset_release_bit,
	input wire logic analog_interface_reset_release_bit,
	input wire logic primaryImageReady,
	input wire logic primary_to_control_wake_interrupt,
	input wire logic [`BOOT_CMD_W-1:0] control_boot_mode_command_register,
	input wire logic controlCmdStrobe,
	input wire logic controlLoadDone,
	output logic primaryInReset,
	output logic controlInReset,
	output logic analogInReset,
	output logic gpioHighZ,
	output logic primaryRunning,
	output logic controlIdle,
	output logic controlRunning,
	output subsys_boot_pkg::boot_source_t control_boot_mode_value,
	output logic controlLoadActive,
	output logic controlBranch,
	output logic controlCmdAck
);
	import subsys_boot_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic analogPinLevel;
	logic digitalPinLevel;
	pin_sync u_sync_analog (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pinIn(analog_reset_pin_n_in),
		.level(analogPinLevel)
	);
	pin_sync u_sync_digital (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pinIn(digital_reset_pin_n_in),
		.level(digitalPinLevel)
	);

	////////////////////////////////////////////////////////////////////////
	// power-on reset counter and reset merging
	logic [`POR_CNT_W-1:0] porCount;
	logic [`POR_CNT_W-1:0] next_porCount;
	logic porActive;
	logic next_porActive;
	logic internalReq;
	logic next_digitalDrive;
	logic next_analogDrive;
	logic deviceReset;
	logic digitalDrive;
	logic analogDrive;
	logic [`REQ_HOLD_W-1:0] reqHold;
	logic [`REQ_HOLD_W-1:0] next_reqHold;

	assign internalReq = intCtrlResetReq | watchdog0ResetReq | watchdog1ResetReq
		| nmiWatchdogResetReq;
	// either pin low (including an outside party extending reset) resets all
	assign deviceReset = porActive | !analogPinLevel | !digitalPinLevel;

	always_comb begin
		next_porCount = porCount;
		next_porActive = porActive;
		next_reqHold = reqHold;
		// a one-cycle request would be filtered out by our own pin synchroniser
		if (internalReq) begin
			next_reqHold = `REQ_HOLD_CYCLES;
		end else if (reqHold != `REQ_HOLD_W'(0)) begin
			next_reqHold = reqHold - `REQ_HOLD_W'(1);
		end
		if (porActive) begin
			if (porCount == `POR_CNT_W'(`POR_CYCLES - 1)) begin
				next_porActive = 1'b0;
			end else begin
				next_porCount = porCount + `POR_CNT_W'(1);
			end
		end
		next_analogDrive = next_porActive;
		// merged requests ANDed (active low) with power-on reset onto digital pin
		next_digitalDrive = next_porActive | internalReq | (reqHold != `REQ_HOLD_W'(0));
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			porCount <= `POR_CNT_W'(0);
			porActive <= 1'b1;
			reqHold <= `REQ_HOLD_W'(0);
			digitalDrive <= 1'b1;
			analogDrive <= 1'b1;
		end else begin
			porCount <= next_porCount;
			porActive <= next_porActive;
			reqHold <= next_reqHold;
			digitalDrive <= next_digitalDrive;
			analogDrive <= next_analogDrive;
		end
	end
	// open drain: only ever drive low
	assign analog_reset_pin_n_out = 1'b0;
	assign digital_reset_pin_n_out = 1'b0;
	assign analog_reset_pin_n_oe = analogDrive;
	assign digital_reset_pin_n_oe = digitalDrive;

	////////////////////////////////////////////////////////////////////////
	// subsystem release and primary boot
	prim_boot_state_t pState;
	prim_boot_state_t next_pState;
	logic next_controlInReset;
	logic next_analogInReset;
	logic next_primaryInReset;
	logic next_gpioHighZ;
	logic next_primaryRunning;

	always_comb begin
		next_pState = pState;
		next_primaryInReset = deviceReset;
		next_gpioHighZ = porActive;
		// release bits are levels; held released only while written 1
		next_controlInReset = deviceReset | !control_reset_release_bit;
		next_analogInReset = deviceReset | !analog_interface_reset_release_bit;
		case (pState)
			PB_RESET: begin
				if (!deviceReset) begin
					next_pState = PB_LOAD;
				end
			end
			PB_LOAD: begin
				if (primaryImageReady) begin
					next_pState = PB_RUN;
				end
			end
			PB_RUN: begin
				next_pState = PB_RUN;
			end
			default: begin
				next_pState = PB_RESET;
			end
		endcase
		if (deviceReset) begin
			next_pState = PB_RESET;
		end
		next_primaryRunning = (next_pState == PB_RUN);
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pState <= PB_RESET;
			primaryInReset <= 1'b1;
			controlInReset <= 1'b1;
			analogInReset <= 1'b1;
			gpioHighZ <= 1'b1;
			primaryRunning <= 1'b0;
		end else begin
			pState <= next_pState;
			primaryInReset <= next_primaryInReset;
			controlInReset <= next_controlInReset;
			analogInReset <= next_analogInReset;
			gpioHighZ <= next_gpioHighZ;
			primaryRunning <= next_primaryRunning;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control boot loader handshake
	boot_source_t decodedSource;
	logic decodedValid;
	boot_cmd_decode u_decode (
		.cmd(control_boot_mode_command_register),
		.source(decodedSource),
		.valid(decodedValid)
	);

	ctrl_boot_state_t cState;
	ctrl_boot_state_t next_cState;
	boot_source_t next_bootValue;
	logic next_controlIdle;
	logic next_controlRunning;
	logic next_controlLoadActive;
	logic next_controlBranch;
	logic next_controlCmdAck;
	logic cmdTaken;

	assign cmdTaken = controlCmdStrobe && decodedValid;

	always_comb begin
		next_cState = cState;
		next_bootValue = control_boot_mode_value;
		next_controlBranch = 1'b0;
		next_controlCmdAck = 1'b0;
		case (cState)
			CB_RESET: begin
				next_cState = CB_INIT;
			end
			CB_INIT: begin
				next_cState = CB_IDLE;
			end
			CB_IDLE: begin
				if (primary_to_control_wake_interrupt) begin
					next_cState = CB_WAIT_CMD;
				end
			end
			CB_WAIT_CMD: begin
				if (cmdTaken) begin
					next_bootValue = decodedSource;
					next_controlCmdAck = 1'b1;
					// RAM and flash already hold the image: branch at once
					if (decodedSource == SRC_RAM || decodedSource == SRC_FLASH) begin
						next_cState = CB_BRANCH;
					end else begin
						next_cState = CB_LOAD;
					end
				end
			end
			CB_LOAD: begin
				if (controlLoadDone) begin
					next_cState = CB_BRANCH;
				end
			end
			CB_BRANCH: begin
				next_controlBranch = 1'b1;
				next_cState = CB_RUN;
			end
			CB_RUN: begin
				// later commands are acknowledged for housekeeping
				if (cmdTaken) begin
					next_bootValue = decodedSource;
					next_controlCmdAck = 1'b1;
				end
			end
			default: begin
				next_cState = CB_RESET;
			end
		endcase
		if (controlInReset) begin
			next_cState = CB_RESET;
			next_bootValue = SRC_NONE;
			next_controlBranch = 1'b0;
			next_controlCmdAck = 1'b0;
		end
		next_controlIdle = (next_cState == CB_IDLE) || (next_cState == CB_WAIT_CMD);
		next_controlRunning = (next_cState == CB_RUN);
		next_controlLoadActive = (next_cState == CB_LOAD);
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cState <= CB_RESET;
			control_boot_mode_value <= SRC_NONE;
			controlIdle <= 1'b0;
			controlRunning <= 1'b0;
			controlLoadActive <= 1'b0;
			controlBranch <= 1'b0;
			controlCmdAck <= 1'b0;
		end else begin
			cState <= next_cState;
			control_boot_mode_value <= next_bootValue;
			controlIdle <= next_controlIdle;
			controlRunning <= next_controlRunning;
			controlLoadActive <= next_controlLoadActive;
			controlBranch <= next_controlBranch;
			controlCmdAck <= next_controlCmdAck;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_waitCmd;
		cState == CB_WAIT_CMD && !controlInReset;
	endsequence
	sequence s_ramCmd;
		controlCmdStrobe && control_boot_mode_command_register == `BOOT_CMD_RAM;
	endsequence

	a_ram_branch: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 s_ramCmd |=> cState == CB_BRANCH ##1 controlBranch)
		else $error("ram command did not branch");
	a_flash_branch: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 controlCmdStrobe
		&& control_boot_mode_command_register == `BOOT_CMD_FLASH
		|=> control_boot_mode_value == SRC_FLASH && cState == CB_BRANCH)
		else $error("flash command did not branch");
	a_serial_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 controlCmdStrobe
		&& control_boot_mode_command_register == `BOOT_CMD_SERIAL
		|=> controlLoadActive && control_boot_mode_value == SRC_SERIAL)
		else $error("serial command did not load");
	a_spi_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 controlCmdStrobe
		&& control_boot_mode_command_register == `BOOT_CMD_SPI
		|=> control_boot_mode_value == SRC_SPI)
		else $error("spi command wrong source");
	a_i2c_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 controlCmdStrobe
		&& control_boot_mode_command_register == `BOOT_CMD_I2C
		|=> control_boot_mode_value == SRC_I2C)
		else $error("i2c command wrong source");
	a_par_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 controlCmdStrobe
		&& control_boot_mode_command_register == `BOOT_CMD_PARALLEL
		|=> control_boot_mode_value == SRC_PARALLEL)
		else $error("parallel command wrong source");
	a_spialt_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 controlCmdStrobe
		&& control_boot_mode_command_register == `BOOT_CMD_SPI_ALT
		|=> control_boot_mode_value == SRC_SPI_ALT)
		else $error("alternate spi command wrong source");
	a_bad_cmd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_waitCmd ##0 !decodedValid |=> cState == CB_WAIT_CMD && !controlBranch)
		else $error("invalid command left wait state");
	a_wake_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cState == CB_IDLE && !primary_to_control_wake_interrupt && !controlInReset
		|=> cState == CB_IDLE)
		else $error("control left idle without wake");
	a_load_branch: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cState == CB_LOAD && controlLoadDone && !controlInReset
		|=> ##1 controlBranch ##1 controlRunning)
		else $error("load completion did not branch");
	a_release_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!control_reset_release_bit |=> controlInReset)
		else $error("control left reset without release");
	a_pin_merge: assert property (@(posedge clk_sys) disable iff (!rst_b)
		watchdog1ResetReq |=> digital_reset_pin_n_oe)
		else $error("watchdog reset not driven on pin");
	a_por_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		porActive |-> analog_reset_pin_n_oe && digital_reset_pin_n_oe ##1 gpioHighZ)
		else $error("power-on reset not holding pins");
	a_joint_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
		deviceReset |=> primaryInReset && controlInReset && analogInReset)
		else $error("subsystems not reset together");
endmodule
`default_nettype wire

// ==== dv/primary_model.sv ====
// primary processor model: release bits, wake interrupt and boot commands
`timescale 1ns/1ps
`default_nettype none
`include "subsys_boot_regs.svh"
module primary_model (
	input wire logic clk_sys,
	output logic wake,
	output logic [`BOOT_CMD_W-1:0] cmd,
	output logic strobe,
	output logic ctrlRelease,
	output logic anaRelease,
	output logic imageReady
);
	initial begin
		wake = 1'b0;
		cmd = 32'h0000_0000;
		strobe = 1'b0;
		ctrlRelease = 1'b0;
		anaRelease = 1'b0;
		imageReady = 1'b0;
	end
	task automatic set_levels(input logic rel, input logic img);
		ctrlRelease = rel;
		anaRelease = rel;
		imageReady = img;
	endtask
	// callers enter just after a clock edge, so each pulse spans one edge
	task automatic send_wake();
		wake = 1'b1;
		@(posedge clk_sys) #1;
		wake = 1'b0;
	endtask
	task automatic send_cmd(input logic [`BOOT_CMD_W-1:0] c);
		cmd = c;
		strobe = 1'b1;
		@(posedge clk_sys) #1;
		strobe = 1'b0;
		// word is not held after the strobe: show a different value
		cmd = ~c;
	endtask
endmodule
`default_nettype wire

// ==== dv/subsystem_reset_boot_handshake_test.sv ====
// self-checking bench for the reset merging and control boot handshake
`timescale 1ns/1ps
`default_nettype none
`include "subsys_boot_regs.svh"
module subsystem_reset_boot_handshake_test;
	import subsys_boot_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic anaOut, anaOe, digOut, digOe, extLow = 1'b0;
	logic [3:0] req = 4'h0;
	logic loadDone = 1'b0;
	logic wake, strobe, ctrlRel, anaRel, imgReady;
	logic [`BOOT_CMD_W-1:0] cmd;
	logic primaryInReset, controlInReset, analogInReset, gpioHighZ, primaryRunning;
	logic controlIdle, controlRunning, controlLoadActive, controlBranch, controlCmdAck;
	boot_source_t bootValue;
	wire logic resetNet;
	int failures = 0;
	int check_count = 0;
	always #2 clk_sys = ~clk_sys;
	// pins tied together with a pull-up; open drain, so only low is driven
	assign resetNet = (anaOe ? anaOut : 1'b1) & (digOe ? digOut : 1'b1) & ~extLow;
	primary_model pm (.clk_sys(clk_sys), .wake(wake), .cmd(cmd), .strobe(strobe),
		.ctrlRelease(ctrlRel), .anaRelease(anaRel), .imageReady(imgReady));
	subsystem_reset_boot_handshake uut (.clk_sys(clk_sys), .rst_b(rst_b),
		.analog_reset_pin_n_in(resetNet), .analog_reset_pin_n_out(anaOut),
		.analog_reset_pin_n_oe(anaOe), .digital_reset_pin_n_in(resetNet),
		.digital_reset_pin_n_out(digOut), .digital_reset_pin_n_oe(digOe),
		.intCtrlResetReq(req[0]), .watchdog0ResetReq(req[1]), .watchdog1ResetReq(req[2]),
		.nmiWatchdogResetReq(req[3]), .control_reset_release_bit(ctrlRel),
		.analog_interface_reset_release_bit(anaRel), .primaryImageReady(imgReady),
		.primary_to_control_wake_interrupt(wake), .control_boot_mode_command_register(cmd),
		.controlCmdStrobe(strobe), .controlLoadDone(loadDone), .primaryInReset(primaryInReset),
		.controlInReset(controlInReset), .analogInReset(analogInReset), .gpioHighZ(gpioHighZ),
		.primaryRunning(primaryRunning), .controlIdle(controlIdle),
		.controlRunning(controlRunning), .control_boot_mode_value(bootValue),
		.controlLoadActive(controlLoadActive), .controlBranch(controlBranch),
		.controlCmdAck(controlCmdAck));
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic step();
		@(posedge clk_sys) #1;
	endtask
	function automatic logic peek(input int sel);
		case (sel)
			0: return primaryInReset;
			1: return controlIdle;
			2: return controlBranch;
			3: return controlRunning;
			default: return primaryRunning;
		endcase
	endfunction
	// bounded wait; running out of cycles closes the run
	task automatic wait_for(input int sel, input logic val, input int limit, input string what);
		int n;
		n = 0;
		while (peek(sel) !== val && n < limit) begin
			step();
			n++;
		end
		check(what, peek(sel), val);
		if (peek(sel) !== val) begin
			give_verdict();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic power_up();
		rst_b = 1'b0;
		pm.set_levels(1'b0, 1'b0);
		repeat (4) step();
		rst_b = 1'b1;
		step();
		check("digital pin drive", digOe, 1'b1);
		check("analog pin drive", anaOe, 1'b1);
		check("gpio high-z", gpioHighZ, 1'b1);
		check("primary reset", primaryInReset, 1'b1);
		wait_for(0, 1'b0, 400, "primary leaves reset");
		check("pin drive released", digOe | anaOe, 1'b0);
		check("control held", controlInReset, 1'b1);
		check("analog held", analogInReset, 1'b1);
		repeat (8) step();
		check("still held", controlInReset | analogInReset, 1'b1);
		check("primary waits image", primaryRunning, 1'b0);
		pm.set_levels(1'b1, 1'b1);
		wait_for(4, 1'b1, 20, "primary running");
		wait_for(1, 1'b1, 20, "control parked idle");
		check("control released", controlInReset | analogInReset, 1'b0);
	endtask
	// full boot for one command; probe adds commands that must be ignored
	task automatic boot_with(input int k, input bit probe);
		power_up();
		if (probe) begin
			pm.send_cmd(32'h0000_0001);
			check("ack before wake", controlCmdAck, 1'b0);
			pm.send_wake();
			pm.send_cmd(32'h0000_0000);
			check("ack zero", controlCmdAck, 1'b0);
			pm.send_cmd(32'h0000_0008);
			check("ack eight", controlCmdAck, 1'b0);
			check("no branch", controlBranch | controlRunning, 1'b0);
			check("stays idle", controlIdle, 1'b1);
		end else begin
			pm.send_wake();
		end
		pm.send_cmd(k);
		check("ack", controlCmdAck, 1'b1);
		check("boot source", bootValue, k);
		check("loading", controlLoadActive, k > 2);
		if (k > 2) begin
			repeat (6) step();
			check("no branch while loading", controlBranch | controlRunning, 1'b0);
			loadDone = 1'b1;
			step();
			loadDone = 1'b0;
		end
		wait_for(2, 1'b1, 4, "branch pulse");
		wait_for(3, 1'b1, 2, "control running");
	endtask
	task automatic later_command();
		pm.send_cmd(`BOOT_CMD_FLASH);
		check("ack after boot", controlCmdAck, 1'b1);
		check("source after boot", bootValue, SRC_FLASH);
	endtask
	task automatic reset_sources();
		for (int i = 0; i < 4; i++) begin
			req[i] = 1'b1;
			step();
			req[i] = 1'b0;
			check("digital pin pulled", digOe, 1'b1);
			wait_for(0, 1'b1, 8, "merged reset");
			step();
			check("all in reset", controlInReset & analogInReset, 1'b1);
			wait_for(0, 1'b0, 400, "recovered");
		end
		extLow = 1'b1;
		wait_for(0, 1'b1, 8, "pin held outside");
		repeat (30) step();
		check("reset extended", primaryInReset & analogInReset, 1'b1);
		extLow = 1'b0;
		wait_for(0, 1'b0, 400, "leave reset");
		repeat (2) step();
		check("leave together", controlInReset | analogInReset, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		boot_with(1, 1'b1);
		for (int k = 2; k <= 7; k++) begin
			boot_with(k, 1'b0);
		end
		later_command();
		reset_sources();
		give_verdict();
	end
endmodule
`default_nettype wire
